// ===== verilog/shadow_map_pkg.sv
// Purpose: Constants and carrier types for the shadow RAM map config bank
// Assumes: Indexed I/O port pair, 8-bit data
// Notes: Offsets are index values, not byte addresses
package shadow_map_pkg;
    // ****************************************************************
    // Ports and indices
    // ****************************************************************
    localparam logic [15:0] INDEX_PORT = 16'h0022;
    localparam logic [15:0] DATA_PORT = 16'h0023;
    localparam logic [7:0] IDX_CONTROLLER_IDENTITY = 8'h64;
    localparam logic [7:0] IDX_ROM_SEGMENT_CONFIG = 8'h65;
    localparam logic [7:0] IDX_LOW_MEMORY_PLACEMENT = 8'h66;
    localparam logic [7:0] IDX_SHADOW_ENABLE_A_B = 8'h67;
    localparam logic [7:0] IDX_SHADOW_ENABLE_C_D = 8'h68;
    localparam logic [7:0] IDX_SHADOW_ENABLE_E_F = 8'h69;
    localparam logic [7:0] IDX_BANK_PAIR_LOW_SETUP = 8'h6a;
    localparam int NUM_REGS = 7;
    // Value parked in the index after each data access
    localparam logic [7:0] IDX_NONE = 8'h00;

    // ****************************************************************
    // Reset values and masks
    // ****************************************************************
    localparam logic [7:0] RST_ROM_SEGMENT_CONFIG = 8'h0e;
    localparam logic [7:0] RST_LOW_MEMORY_PLACEMENT = 8'h00;
    localparam logic [7:0] RST_SHADOW_ENABLE = 8'h00;
    localparam logic [7:0] RST_BANK_PAIR_LOW_SETUP = 8'h9f;
    localparam logic [7:0] MASK_LOW_MEM_ORIG = 8'h80;
    localparam logic [7:0] MASK_LOW_MEM_LATER = 8'he0;
    localparam logic [7:0] BANK_RSVD_ONES = 8'h1f;
    localparam logic [4:0] ID_RSVD = 5'h00;

    // ****************************************************************
    // Memory map
    // ****************************************************************
    localparam int ADDR_W = 20;
    localparam logic [3:0] SEG_A = 4'ha;
    localparam logic [3:0] SEG_B = 4'hb;
    localparam logic [3:0] SEG_C = 4'hc;
    localparam logic [3:0] SEG_D = 4'hd;
    localparam logic [3:0] SEG_E = 4'he;
    localparam logic [3:0] SEG_F = 4'hf;
    localparam logic [1:0] LOW_Q0 = 2'h0;
    localparam logic [1:0] LOW_Q1 = 2'h1;
    localparam logic [2:0] HI_8_9_MSB = 3'h4;

    typedef enum logic [1:0] {
        DRAM_DISABLED = 2'b00,
        DRAM_MIXED_256_64 = 2'b01,
        DRAM_256K = 2'b10,
        DRAM_1M = 2'b11
    } dram_type_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } io_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic wr;
        logic valid;
    } mem_req_t;

    typedef struct packed {
        logic rom_chip_select;
        logic shadow_hit;
        logic write_blocked;
        logic board_ram;
        logic drive_mem_addr;
    } mem_dec_t;
endpackage : shadow_map_pkg

// ===== verilog/shadow_reg_store.sv
// Purpose: Small register store for the writable configuration bytes
// Assumes: One write port, registered read data
// Notes: Entry 0 is unused; identity is not stored
`timescale 1ns/1ps
`default_nettype none
module shadow_reg_store
    import shadow_map_pkg::*;
#(
    parameter int DEPTH = NUM_REGS
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [2:0] wr_sel_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [2:0] rd_sel_i,
    output logic [7:0] rd_data_o,
    output logic [DEPTH*8-1:0] all_o
);
    // ****************************************************************
    // Storage, one generate entry per register
    // ****************************************************************
    logic [7:0] mem_q [DEPTH];
    logic [7:0] mem_d [DEPTH];
    logic [7:0] rst_val [DEPTH];
    logic [7:0] rd_q;
    logic [7:0] rd_d;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_comb begin
                case (g)
                    1: rst_val[g] = RST_ROM_SEGMENT_CONFIG;
                    2: rst_val[g] = RST_LOW_MEMORY_PLACEMENT;
                    6: rst_val[g] = RST_BANK_PAIR_LOW_SETUP;
                    default: rst_val[g] = RST_SHADOW_ENABLE;
                endcase
                mem_d[g] = mem_q[g];
                if (wr_en_i && wr_sel_i == 3'(g)) begin
                    mem_d[g] = wr_data_i;
                end
            end
            always_ff @(posedge clk_sys_i) begin
                mem_q[g] <= rst_i ? rst_val[g] : mem_d[g];
            end
            assign all_o[g*8 +: 8] = mem_q[g];
        end
    endgenerate

    always_comb begin
        rd_d = (int'(rd_sel_i) < DEPTH) ? mem_q[rd_sel_i] : 8'h00;
    end

    always_ff @(posedge clk_sys_i) begin
        rd_q <= rst_i ? 8'h00 : rd_d;
    end

    assign rd_data_o = rd_q;
endmodule : shadow_reg_store
`default_nettype wire

// ===== verilog/shadow_ram_map_config.sv
// Purpose: Indexed configuration bank and memory map decode
// Assumes: I/O and memory requests already synchronous to clk_sys_i
// Notes: Read data valid two cycles after the data-port read strobe
// Functional notes
// RULE1 - Index port selects, data port moves data
// RULE2 - Host rewrites index before each data access
// RULE3 - Read-only identity: identifier, revision, zeros
// RULE4 - Bit0 zero enables BIOS ROM select
// RULE5 - Bits1-3 one suppress ROM, enable shadow; code only clears ROM select, shadow hits come from the 16K enables alone
// RULE6 - Bits4-7 one write-protect F,E,D,C shadow
// RULE7 - Bit7 claims 80000H-9FFFFH for board RAM
// RULE8 - Later revision bits5,6 move low regions
// RULE9 - A/B 16K shadow enables, ascending; code maps B blocks to bits 0-3, A blocks to bits 4-7
// RULE10 - C/D 16K shadow enables, ascending
// RULE11 - E/F 16K shadow enables, ascending
// RULE12 - Bank bit5 count, bits0-4 reserved ones
// RULE13 - Bits7,6 select DRAM type
// RULE14 - Unknown index: writes ignored, bus undriven
`timescale 1ns/1ps
`default_nettype none
module shadow_ram_map_config
    import shadow_map_pkg::*;
#(
    parameter logic CONTROLLER_ID = 1'b1,       // Arbitrary value
    parameter logic [1:0] REVISION = 2'b01,     // Arbitrary value
    parameter logic LATER_REVISION = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire io_req_t io_req_i,
    input wire mem_req_t mem_req_i,
    output logic [7:0] io_rdata_o,
    output logic io_rdata_oe_o,
    output mem_dec_t mem_dec_o,
    output dram_type_t dram_type_o,
    output logic two_banks_o
);
    // ****************************************************************
    // Port decode and index
    // ****************************************************************
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_FETCH = 2'b01,
        RD_DRIVE = 2'b11
    } rd_state_t;

    logic [7:0] index_q;
    logic [7:0] index_d;
    rd_state_t rd_q;
    rd_state_t rd_d;
    logic id_sel_q;
    logic id_sel_d;
    logic idx_hit;
    logic [2:0] sel;
    logic data_wr;
    logic data_rd;
    logic st_wr;
    logic [7:0] st_wdata;
    logic [7:0] st_rdata;
    logic [NUM_REGS*8-1:0] regs;
    logic [7:0] identity;

    assign idx_hit = (index_q >= IDX_CONTROLLER_IDENTITY)
        && (index_q <= IDX_BANK_PAIR_LOW_SETUP);                 // [RULE1] [RULE14]
    assign sel = 3'(index_q - IDX_CONTROLLER_IDENTITY);          // [RULE1]
    assign data_wr = io_req_i.wr && (io_req_i.addr == DATA_PORT);
    assign data_rd = io_req_i.rd && (io_req_i.addr == DATA_PORT);
    assign identity = {CONTROLLER_ID, REVISION, ID_RSVD};         // [RULE3]

    // Write masking keeps reserved bits at their defined values
    always_comb begin
        st_wr = data_wr && idx_hit
            && (index_q != IDX_CONTROLLER_IDENTITY);             // [RULE3] [RULE14]
        st_wdata = io_req_i.wdata;
        case (index_q)
            IDX_LOW_MEMORY_PLACEMENT: begin
                st_wdata = io_req_i.wdata & (LATER_REVISION ?
                    MASK_LOW_MEM_LATER : MASK_LOW_MEM_ORIG);     // [RULE8]
            end
            IDX_BANK_PAIR_LOW_SETUP: begin
                st_wdata = io_req_i.wdata | BANK_RSVD_ONES;      // [RULE12]
            end
            default: begin
                st_wdata = io_req_i.wdata;
            end
        endcase
    end

    // Each data access consumes the index, so stale repeats hit nothing
    always_comb begin
        index_d = index_q;
        if (io_req_i.wr && io_req_i.addr == INDEX_PORT) begin
            index_d = io_req_i.wdata;                            // [RULE1]
        end else if (data_wr || data_rd) begin
            index_d = IDX_NONE;                                  // [RULE2]
        end
    end

    always_comb begin
        rd_d = rd_q;
        id_sel_d = id_sel_q;
        case (rd_q)
            RD_IDLE: begin
                if (data_rd && idx_hit) begin                    // [RULE14]
                    rd_d = RD_FETCH;
                    id_sel_d = (index_q == IDX_CONTROLLER_IDENTITY);
                end
            end
            RD_FETCH: rd_d = RD_DRIVE;
            RD_DRIVE: rd_d = RD_IDLE;
            default: rd_d = RD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            index_q <= IDX_NONE;
            rd_q <= RD_IDLE;
            id_sel_q <= 1'b0;
        end else begin
            index_q <= index_d;
            rd_q <= rd_d;
            id_sel_q <= id_sel_d;
        end
    end

    shadow_reg_store #(
        .DEPTH(NUM_REGS)
    ) u_store (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wr_en_i(st_wr),
        .wr_sel_i(sel),
        .wr_data_i(st_wdata),
        .rd_sel_i(sel),
        .rd_data_o(st_rdata),
        .all_o(regs)
    );

    // ****************************************************************
    // Memory map decode
    // ****************************************************************
    logic [7:0] rom_cfg;
    logic [7:0] low_cfg;
    logic [7:0] bank_cfg;
    logic [23:0] shadow_blk;
    logic [3:0] seg;
    logic [1:0] blk;
    logic [2:0] ab_sel;
    logic [4:0] cf_sel;
    mem_dec_t dec_d;
    mem_dec_t dec_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic oe_d;
    logic oe_q;

    assign rom_cfg = regs[8 +: 8];
    assign low_cfg = regs[16 +: 8];
    assign shadow_blk = regs[24 +: 24];                           // [RULE9] [RULE10] [RULE11]
    assign bank_cfg = regs[48 +: 8];
    assign seg = mem_req_i.addr[19:16];
    assign blk = mem_req_i.addr[15:14];

    always_comb begin
        dec_d = '0;
        ab_sel = {~seg[0], blk};                                  // [RULE9]
        cf_sel = 5'({seg - SEG_C, blk}) + 5'h08;                  // [RULE10] [RULE11]
        if (mem_req_i.valid) begin
            case (seg)
                SEG_A, SEG_B: begin
                    dec_d.shadow_hit = shadow_blk[ab_sel];         // [RULE9]
                end
                SEG_C, SEG_D, SEG_E, SEG_F: begin
                    dec_d.shadow_hit = shadow_blk[cf_sel];         // [RULE10] [RULE11]
                    if (seg == SEG_F) begin
                        dec_d.rom_chip_select = !rom_cfg[0]
                            && !mem_req_i.wr;                      // [RULE4]
                    end else begin
                        dec_d.rom_chip_select = !rom_cfg[3'(SEG_F - seg)]
                            && !mem_req_i.wr;                      // [RULE5]
                    end
                    dec_d.write_blocked = mem_req_i.wr
                        && rom_cfg[3'(4 + 2'(SEG_F - seg))];      // [RULE6]
                end
                default: begin
                    if (seg[3:1] == HI_8_9_MSB) begin
                        dec_d.board_ram = low_cfg[7];              // [RULE7]
                        dec_d.drive_mem_addr = low_cfg[7];         // [RULE7]
                    end else if (seg[3:2] == LOW_Q0) begin
                        dec_d.board_ram = !(LATER_REVISION && low_cfg[5]); // [RULE8]
                        dec_d.drive_mem_addr = dec_d.board_ram;
                    end else begin
                        dec_d.board_ram = !(LATER_REVISION && low_cfg[6]); // [RULE8]
                        dec_d.drive_mem_addr = dec_d.board_ram;
                    end
                end
            endcase
            if (dec_d.shadow_hit) begin
                dec_d.rom_chip_select = 1'b0;
                dec_d.board_ram = !dec_d.write_blocked;
                dec_d.drive_mem_addr = 1'b1;
            end
        end
    end

    // Bus drive lasts one cycle in RD_DRIVE only
    always_comb begin
        oe_d = (rd_q == RD_FETCH);                                // [RULE14]
        rdata_d = 8'h00;
        if (rd_q == RD_FETCH) begin
            rdata_d = id_sel_q ? identity : st_rdata;              // [RULE3]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dec_q <= '0;
            rdata_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            dec_q <= dec_d;
            rdata_q <= rdata_d;
            oe_q <= oe_d;
        end
    end

    // Registered copies of bank setup fields
    dram_type_t dram_q;
    logic banks_q;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dram_q <= DRAM_256K;
            banks_q <= 1'b0;
        end else begin
            dram_q <= dram_type_t'(bank_cfg[7:6]);                 // [RULE13]
            banks_q <= bank_cfg[5];                                // [RULE12]
        end
    end

    assign mem_dec_o = dec_q;
    assign io_rdata_o = rdata_q;
    assign io_rdata_oe_o = oe_q;
    assign dram_type_o = dram_q;
    assign two_banks_o = banks_q;
endmodule : shadow_ram_map_config
`default_nettype wire

// ===== test/shadow_map_checker.sv
// Purpose: Port-level assertions for the shadow RAM map config bank
// Assumes: Index and ROM config mirrored from port traffic
// Notes: Attached by bind from the bench top
`timescale 1ns/1ps
`default_nettype none
module shadow_map_checker
    import shadow_map_pkg::*;
#(
    parameter logic CONTROLLER_ID = 1'b1,       // Arbitrary value
    parameter logic [1:0] REVISION = 2'b01      // Arbitrary value
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire io_req_t io_req_i,
    input wire mem_req_t mem_req_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_rdata_oe_o,
    input wire mem_dec_t mem_dec_o,
    input wire dram_type_t dram_type_o,
    input wire logic two_banks_o
);
    // ****
    // Mirror of index and ROM config
    // ****
    logic [7:0] idx_q, idx_d, rom_q, rom_d;
    logic data_acc;
    logic mapped;
    assign data_acc = (io_req_i.wr || io_req_i.rd) && io_req_i.addr == DATA_PORT;
    assign mapped = idx_q >= IDX_CONTROLLER_IDENTITY && idx_q <= IDX_BANK_PAIR_LOW_SETUP;
    always_comb begin
        idx_d = idx_q;
        rom_d = rom_q;
        if (io_req_i.wr && io_req_i.addr == INDEX_PORT) begin
            idx_d = io_req_i.wdata;
        end else if (data_acc) begin
            idx_d = IDX_NONE;
            if (io_req_i.wr && idx_q == IDX_ROM_SEGMENT_CONFIG) begin
                rom_d = io_req_i.wdata;
            end
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            idx_q <= 8'h00;
            rom_q <= 8'h0e;
        end else begin
            idx_q <= idx_d;
            rom_q <= rom_d;
        end
    end
    // ****
    // Assertions
    // ****
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_read_answer: assert property (
        io_req_i.rd && data_acc && mapped |-> ##1 !io_rdata_oe_o ##1 io_rdata_oe_o ##1 !io_rdata_oe_o)
        else $error("mapped read not answered after two cycles");
    a_unmapped_quiet: assert property (
        io_req_i.rd && data_acc && !mapped |-> ##2 !io_rdata_oe_o)
        else $error("unmapped read drove the bus");
    a_oe_cause: assert property (
        io_rdata_oe_o |-> $past(io_req_i.rd && data_acc && mapped, 2))
        else $error("bus driven without a mapped read");
    a_identity_value: assert property (
        io_rdata_oe_o && $past(idx_q, 2) == IDX_CONTROLLER_IDENTITY
        |-> io_rdata_o == {CONTROLLER_ID, REVISION, 5'h00})
        else $error("identity byte wrong");
    a_write_protect: assert property (
        mem_req_i.valid && mem_req_i.wr && mem_req_i.addr[19:18] == 2'b11
        |-> ##1 mem_dec_o.write_blocked == $past(rom_q[7 - mem_req_i.addr[17:16]]))
        else $error("write protect does not follow ROM config");
    a_rom_cause: assert property (
        mem_dec_o.rom_chip_select |-> $past(mem_req_i.valid && !mem_req_i.wr
        && mem_req_i.addr[19:18] == 2'b11 && !rom_q[3 - mem_req_i.addr[17:16]]))
        else $error("ROM select outside an enabled ROM segment");
    a_shadow_kills_rom: assert property (
        mem_dec_o.shadow_hit |-> !mem_dec_o.rom_chip_select && mem_dec_o.drive_mem_addr)
        else $error("shadow hit with ROM select");
    a_bank_follow: assert property (
        io_req_i.wr && data_acc && idx_q == IDX_BANK_PAIR_LOW_SETUP
        |-> ##2 {dram_type_o, two_banks_o} == $past(io_req_i.wdata[7:5], 2))
        else $error("bank outputs do not follow register");
    a_reset_state: assert property (disable iff (1'b0)
        rst_i |=> dram_type_o == DRAM_256K && !two_banks_o && !io_rdata_oe_o && mem_dec_o == '0)
        else $error("outputs wrong after reset");
endmodule : shadow_map_checker
`default_nettype wire

// ===== test/io_host_model.sv
// Purpose: Host model on the index/data port pair and memory cycles
// Assumes: Requests change at falling edges
// Notes: Released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module io_host_model
    import shadow_map_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic oe_i,
    input wire mem_dec_t dec_i,
    output io_req_t io_o,
    output mem_req_t mem_o
);
    // ****
    // Bus cycles
    // ****
    initial begin
        io_o = '0;
        mem_o = '0;
    end
    task automatic put(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
        @(negedge clk_i);
        io_o = '{a, d, w, r};
    endtask : put
    task automatic idle();
        put(~io_o.addr, ~io_o.wdata, 1'b0, 1'b0);
    endtask : idle
    // Index rewritten ahead of each data access
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
        put(INDEX_PORT, idx, 1'b1, 1'b0);
        put(DATA_PORT, v, 1'b1, 1'b0);
        idle();
    endtask : wr_reg
    // Stale index only when a test wants a refusal
    task automatic rd_reg(input logic [7:0] idx, input logic fresh, output logic [7:0] v,
                          output logic ok);
        if (fresh) put(INDEX_PORT, idx, 1'b1, 1'b0);
        put(DATA_PORT, 8'h00, 1'b0, 1'b1);
        idle();
        // Answer stands only between the second and third edge after the strobe
        @(negedge clk_i);
        v = rdata_i;
        ok = oe_i;
    endtask : rd_reg
    task automatic mem(input logic [19:0] a, input logic w, output mem_dec_t d);
        @(negedge clk_i);
        mem_o = '{a, w, 1'b1};
        @(negedge clk_i);
        d = dec_i;
        mem_o = '{~a, ~w, 1'b0};
    endtask : mem
endmodule : io_host_model
`default_nettype wire

// ===== test/test_shadow_ram_map_config.sv
// Purpose: Self-checking bench for the shadow RAM map config bank
// Assumes: Host model drives the ports at falling edges
// Notes: Each test starts from a fresh reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module test_shadow_ram_map_config
    import shadow_map_pkg::*;
;
    localparam logic CID = 1'b1; // Arbitrary value
    localparam logic [1:0] REV = 2'b01; // Arbitrary value
    logic clk_sys_i;
    logic rst_i;
    io_req_t io_req;
    mem_req_t mem_req;
    logic [7:0] io_rdata;
    logic io_rdata_oe;
    mem_dec_t mem_dec;
    dram_type_t dram_type;
    logic two_banks;
    int mismatches = 0;
    int n_checks = 0;
    logic [7:0] v;
    logic ok;
    mem_dec_t d;
    shadow_ram_map_config #(.CONTROLLER_ID(CID), .REVISION(REV), .LATER_REVISION(1'b1))
        shadow_ram_map_config_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .io_req_i(io_req),
        .mem_req_i(mem_req), .io_rdata_o(io_rdata), .io_rdata_oe_o(io_rdata_oe),
        .mem_dec_o(mem_dec), .dram_type_o(dram_type), .two_banks_o(two_banks));
    io_host_model io_host_model_inst (.clk_i(clk_sys_i), .rdata_i(io_rdata),
        .oe_i(io_rdata_oe), .dec_i(mem_dec), .io_o(io_req), .mem_o(mem_req));
    // ****
    // Tests
    // ****
    task automatic do_reset();
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'b0;
    endtask : do_reset
    task automatic chk_regs(input logic [55:0] exp);
        for (int i = 0; i < 7; i++) begin
            io_host_model_inst.rd_reg(IDX_CONTROLLER_IDENTITY + 8'(i), 1'b1, v, ok);
            `CHK({ok, v}, {1'b1, exp[8*(6-i) +: 8]})
        end
    endtask : chk_regs
    task automatic t_reset();
        do_reset();
        `CHK({dram_type, two_banks}, 3'b100)
        chk_regs({CID, REV, 5'h00, 8'h0e, 8'h00, 8'h00, 8'h00, 8'h00, 8'h9f});
        $display("t_reset done");
    endtask : t_reset
    task automatic t_access();
        do_reset();
        for (int i = 0; i < 7; i++) io_host_model_inst.wr_reg(8'h64 + 8'(i), 8'hff);
        io_host_model_inst.wr_reg(8'h6b, 8'h00);
        chk_regs({CID, REV, 5'h00, 8'hff, 8'he0, 8'hff, 8'hff, 8'hff, 8'hff});
        io_host_model_inst.rd_reg(8'h6b, 1'b1, v, ok);
        `CHK(ok, 1'b0)
        io_host_model_inst.rd_reg(8'h65, 1'b0, v, ok);
        `CHK(ok, 1'b0)
        $display("t_access done");
    endtask : t_access
    task automatic t_rom();
        logic [23:0] cfg;
        cfg = 24'h0ea55a;
        do_reset();
        for (int k = 2; k >= 0; k--) begin
            io_host_model_inst.wr_reg(IDX_ROM_SEGMENT_CONFIG, cfg[8*k +: 8]);
            for (int s = 12; s < 16; s++) begin
                io_host_model_inst.mem({4'(s), 16'h1234}, 1'b0, d);
                `CHK(d.rom_chip_select, ~cfg[8*k + 15 - s])
                io_host_model_inst.mem({4'(s), 16'h1234}, 1'b1, d);
                `CHK(d.write_blocked, cfg[8*k + 19 - s])
            end
        end
        $display("t_rom done");
    endtask : t_rom
    task automatic t_shadow();
        logic [19:0] a;
        do_reset();
        for (int i = 0; i < 24; i++) begin
            a = (i < 4) ? 20'hb0000 + 20'(i) * 20'h4000 : (i < 8) ?
                20'ha0000 + 20'(i - 4) * 20'h4000 : 20'hc0000 + 20'(i - 8) * 20'h4000;
            io_host_model_inst.wr_reg(IDX_SHADOW_ENABLE_A_B + 8'(i / 8), 8'h01 << (i % 8));
            io_host_model_inst.mem(a + 20'h3fff, 1'b0, d);
            `CHK({d.shadow_hit, d.drive_mem_addr, d.rom_chip_select}, 3'b110)
            io_host_model_inst.mem(a + 20'h4000, 1'b0, d);
            `CHK(d.shadow_hit, 1'b0)
            io_host_model_inst.wr_reg(IDX_SHADOW_ENABLE_A_B + 8'(i / 8), 8'h00);
        end
        $display("t_shadow done");
    endtask : t_shadow
    task automatic t_low();
        logic [55:0] cfg;
        logic [139:0] adr;
        logic [6:0] exp;
        cfg = 56'h00_00_80_20_20_40_40;
        adr = 140'h80000_00000_9ffff_3ffff_40000_3ffff_40000;
        exp = 7'b0110110;
        do_reset();
        for (int i = 6; i >= 0; i--) begin
            io_host_model_inst.wr_reg(IDX_LOW_MEMORY_PLACEMENT, cfg[8*i +: 8]);
            io_host_model_inst.mem(adr[20*i +: 20], 1'b0, d);
            `CHK(d.board_ram, exp[i])
            if (i == 4) `CHK(d.drive_mem_addr, 1'b1)
        end
        `CHK(d.drive_mem_addr, 1'b0)
        $display("t_low done");
    endtask : t_low
    task automatic t_bank();
        do_reset();
        for (int t = 0; t < 4; t++) begin
            io_host_model_inst.wr_reg(IDX_BANK_PAIR_LOW_SETUP, {2'(t), t[0], 5'h00});
            io_host_model_inst.rd_reg(IDX_BANK_PAIR_LOW_SETUP, 1'b1, v, ok);
            `CHK({ok, v}, {1'b1, 2'(t), t[0], 5'h1f})
            `CHK({dram_type, two_banks}, {2'(t), t[0]})
        end
        $display("t_bank done");
    endtask : t_bank
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    // ****
    // Clock, watchdog, sequence
    // ****
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
    initial begin
        rst_i = 1'b1;
        t_reset();
        t_access();
        t_rom();
        t_shadow();
        t_low();
        t_bank();
        end_sim();
    end
endmodule : test_shadow_ram_map_config
bind shadow_ram_map_config shadow_map_checker #(.CONTROLLER_ID(CONTROLLER_ID),
    .REVISION(REVISION)) shadow_map_checker_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .io_req_i(io_req_i), .mem_req_i(mem_req_i), .io_rdata_o(io_rdata_o),
    .io_rdata_oe_o(io_rdata_oe_o), .mem_dec_o(mem_dec_o), .dram_type_o(dram_type_o),
    .two_banks_o(two_banks_o));
`default_nettype wire
